// file: mfs_pkg.sv
// Package of constants for the modem format/sync configuration block.
// Assumes one 40 MHz clock and an active-low asynchronous reset.
// Overview of operation
// - Bit 7 bypasses the DC blocking filter
// - Host bypasses filter only at 250 kBaud or less
// - Host reprograms IF after bypassing the filter (host only sets an IF-stale status flag when bit 7 changes)
// - Bits 6:4 select modulation; reserved codes forbidden
// - Host never combines Manchester with 4-FSK
// - Bit 3 enables Manchester; host clears when illegal (host refuses the whole write and sets the refused flag instead)
// - Qualifier 0 or 4: no preamble/sync detection
// - Qualifier 1 or 5: 15 of 16 bits
// - Qualifier 2 or 6: all 16 bits
// - Qualifier 3 or 7: 30 of 32 bits
// - Qualifiers 4 to 7 also need carrier sense
package mfs_pkg;
    localparam logic [7:0] MFS_CFG_ADDR = 8'h12;
    localparam logic [7:0] MFS_CFG_RESET = 8'h02;
    localparam int MFS_BYPASS_BIT = 7;
    localparam int MFS_MOD_LSB = 4;
    localparam int MFS_MANCH_BIT = 3;
    localparam int MFS_SYNC_LSB = 0;
    localparam int MFS_BYPASS_MAX_KBAUD = 250;
    localparam logic [2:0] MFS_MOD_2FSK = 3'h0;
    localparam logic [2:0] MFS_MOD_GFSK = 3'h1;
    localparam logic [2:0] MFS_MOD_OOK = 3'h3;
    localparam logic [2:0] MFS_MOD_4FSK = 3'h4;
    localparam logic [4:0] MFS_TOL16 = 5'h0F;
    localparam logic [5:0] MFS_TOL32 = 6'h1E;
    localparam logic [7:0] MFS_WB_CTRL = 8'h00;
    localparam logic [7:0] MFS_WB_DATA = 8'h04;
    localparam logic [7:0] MFS_WB_STAT = 8'h08;
endpackage : mfs_pkg

// file: mfs_if.sv
// Serial-free parallel configuration port between host and modem.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
interface mfs_if;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport dev (input wr_en, input wr_data, output rd_data);
    modport host (output wr_en, output wr_data, input rd_data);
endinterface : mfs_if

// file: mfs_sync_match.sv
// Sync word comparator with bit-error tolerance.
// Assumes rx_bit_i is already synchronised to clk_i.
`timescale 1ns/1ps
module mfs_sync_match (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic rx_bit_i,
    input wire logic rx_valid_i,
    input wire logic [15:0] sync_word_i,
    input wire logic [2:0] sync_mode_i,
    input wire logic carrier_i,
    output logic found_o
);
    logic [31:0] shift_q;
    logic [5:0] m16;
    logic [5:0] m32;
    logic [31:0] want;
    logic hit;
    // Shift received bits in
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_q <= 32'h0000_0000;
        end else if (rx_valid_i) begin
            shift_q <= {shift_q[30:0], rx_bit_i};
        end
    end
    // Count matching bits; 32-bit word is the 16-bit word twice
    always_comb begin
        want = {sync_word_i, sync_word_i};
        m16 = 6'h00;
        m32 = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (shift_q[i] == want[i]) begin
                m32 = m32 + 6'h01;
                if (i < 16) begin
                    m16 = m16 + 6'h01;
                end
            end
        end
    end
    // Qualifier decode
    always_comb begin
        unique case (sync_mode_i[1:0])
            2'h0: hit = sync_mode_i[2];
            2'h1: hit = m16 >= {1'b0, mfs_pkg::MFS_TOL16};
            2'h2: hit = m16 == 6'h10;
            2'h3: hit = m32 >= mfs_pkg::MFS_TOL32;
        endcase
    end
    // Carrier gating for upper qualifiers; registered result
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            found_o <= 1'b0;
        end else begin
            found_o <= hit && (!sync_mode_i[2] || carrier_i);
        end
    end
endmodule : mfs_sync_match

// file: mfs_dev.sv
// Device end: configuration register and the datapath controls it steers.
// Assumes host writes through mfs_if; rx inputs are asynchronous pins.
`timescale 1ns/1ps
module mfs_dev (
    input wire logic clk_i,
    input wire logic rst_b_i,
    mfs_if.dev cfg,
    input wire logic rx_bit_i,
    input wire logic rx_valid_i,
    input wire logic carrier_i,
    input wire logic tx_bit_i,
    input wire logic [15:0] sync_word_i,
    output logic dc_filter_bypass_o,
    output logic [2:0] modulation_select_o,
    output logic manchester_en_o,
    output logic tx_chip_o,
    output logic sync_found_o
);
    logic [7:0] cfg_q;
    logic [2:0] rx_bit_s;
    logic [2:0] rx_val_s;
    logic [1:0] cs_s;
    logic rx_strobe;
    logic rx_chip_q;
    logic first_chip_q;
    logic match_bit;
    logic match_vld;
    logic half_q;
    logic found;
    // Configuration register, reads back as written
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_q <= mfs_pkg::MFS_CFG_RESET;
        end else if (cfg.wr_en) begin
            cfg_q <= cfg.wr_data;
        end
    end
    assign cfg.rd_data = cfg_q;
    // Register-driven datapath controls
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dc_filter_bypass_o <= 1'b0;
            modulation_select_o <= mfs_pkg::MFS_MOD_2FSK;
            manchester_en_o <= 1'b0;
        end else begin
            dc_filter_bypass_o <= cfg_q[mfs_pkg::MFS_BYPASS_BIT];
            modulation_select_o <= cfg_q[mfs_pkg::MFS_MOD_LSB +: 3];
            manchester_en_o <= cfg_q[mfs_pkg::MFS_MANCH_BIT];
        end
    end
    // Two-flop synchronisers for pins; third stage for edge use
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_bit_s <= 3'h0;
            rx_val_s <= 3'h0;
            cs_s <= 2'h0;
        end else begin
            rx_bit_s <= {rx_bit_s[1:0], rx_bit_i};
            rx_val_s <= {rx_val_s[1:0], rx_valid_i};
            cs_s <= {cs_s[0], carrier_i};
        end
    end
    // Manchester: two chips per bit, decode takes first chip
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            half_q <= 1'b0;
            tx_chip_o <= 1'b0;
        end else begin
            half_q <= manchester_en_o ? ~half_q : 1'b0;
            tx_chip_o <= manchester_en_o ? (tx_bit_i ^ half_q) : tx_bit_i;
        end
    end
    // Raw strobe on the rising edge of the synchronised valid pin
    assign rx_strobe = rx_val_s[1] & ~rx_val_s[2];
    // Manchester pairs count from enable; a lost chip slips the pairing
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_chip_q <= 1'b0;
            first_chip_q <= 1'b0;
        end else if (!manchester_en_o) begin
            rx_chip_q <= 1'b0;
        end else if (rx_strobe) begin
            rx_chip_q <= ~rx_chip_q;
            first_chip_q <= rx_bit_s[1];
        end
    end
    // First chip carries the bit; the second chip closes the pair
    assign match_bit = manchester_en_o ? first_chip_q : rx_bit_s[1];
    assign match_vld = rx_strobe & (!manchester_en_o || rx_chip_q);
    mfs_sync_match u_match (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .rx_bit_i(match_bit),
        .rx_valid_i(match_vld),
        .sync_word_i(sync_word_i),
        .sync_mode_i(cfg_q[mfs_pkg::MFS_SYNC_LSB +: 3]),
        .carrier_i(cs_s[1]),
        .found_o(found)
    );
    // Output register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_found_o <= 1'b0;
        end else begin
            sync_found_o <= found;
        end
    end
endmodule : mfs_dev

// file: mfs_host.sv
// Host end: Wishbone slave that software uses to program the modem.
// Assumes classic Wishbone on clk_i; device at far side of mfs_if.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module mfs_host (
    input wire logic clk_i,
    input wire logic rst_b_i,
    mfs_if.host cfg,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic cfg_wr_en_o,
    output logic [7:0] cfg_wr_data_o
);
    logic [8:0] kbaud_q;
    logic [7:0] shadow_q;
    logic refused_q;
    logic if_stale_q;
    logic req;
    logic [7:0] want;
    logic legal;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign want = wb_dat_i[7:0];
    // Screen writes that the device must never see
    always_comb begin
        legal = 1'b1;
        if (want[6:4] != mfs_pkg::MFS_MOD_2FSK &&
            want[6:4] != mfs_pkg::MFS_MOD_GFSK &&
            want[6:4] != mfs_pkg::MFS_MOD_OOK &&
            want[6:4] != mfs_pkg::MFS_MOD_4FSK) begin
            legal = 1'b0;
        end
        if (want[3] && want[6:4] == mfs_pkg::MFS_MOD_4FSK) begin
            legal = 1'b0;
        end
        if (want[3] && kbaud_q[8]) begin
            legal = 1'b0;
        end
        if (want[7] && kbaud_q[7:0] > 8'(mfs_pkg::MFS_BYPASS_MAX_KBAUD)) begin
            legal = 1'b0;
        end
    end
    // Bus answer one cycle after the request
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            if (req) begin
                unique case (wb_adr_i)
                    mfs_pkg::MFS_WB_CTRL, mfs_pkg::MFS_WB_DATA,
                    mfs_pkg::MFS_WB_STAT: wb_ack_o <= 1'b1;
                    default: wb_err_o <= 1'b1;
                endcase
                unique case (wb_adr_i)
                    mfs_pkg::MFS_WB_CTRL: wb_dat_o <= {23'h0, kbaud_q};
                    mfs_pkg::MFS_WB_DATA: wb_dat_o <= {24'h0, cfg.rd_data};
                    mfs_pkg::MFS_WB_STAT:
                        wb_dat_o <= {30'h0, if_stale_q, refused_q};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    // Software state, legal forwarding and IF-reprogram reminder
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            kbaud_q <= 9'h000;
            shadow_q <= mfs_pkg::MFS_CFG_RESET;
            refused_q <= 1'b0;
            if_stale_q <= 1'b0;
            cfg_wr_en_o <= 1'b0;
            cfg_wr_data_o <= mfs_pkg::MFS_CFG_RESET;
        end else begin
            cfg_wr_en_o <= 1'b0;
            if (req && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == mfs_pkg::MFS_WB_CTRL) begin
                    kbaud_q <= {wb_sel_i[1] ? wb_dat_i[8] : kbaud_q[8],
                                wb_dat_i[7:0]};
                end else if (wb_adr_i == mfs_pkg::MFS_WB_DATA) begin
                    if (legal) begin
                        cfg_wr_en_o <= 1'b1;
                        cfg_wr_data_o <= want;
                        shadow_q <= want;
                        if (want[7] != shadow_q[7]) begin
                            if_stale_q <= 1'b1;
                        end
                    end else begin
                        refused_q <= 1'b1;
                    end
                end else if (wb_adr_i == mfs_pkg::MFS_WB_STAT) begin
                    refused_q <= refused_q & ~wb_dat_i[0];
                    if_stale_q <= if_stale_q & ~wb_dat_i[1];
                end
            end
        end
    end
    assign cfg.wr_en = cfg_wr_en_o;
    assign cfg.wr_data = cfg_wr_data_o;
endmodule : mfs_host

// file: mfs_checker.sv
// Checker on the host-to-modem configuration link.
// Assumes mfs_if signals plus the modem's decoded outputs, one clock.
`timescale 1ns/1ps
module mfs_checker (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic dc_filter_bypass_o,
    input wire logic [2:0] modulation_select_o,
    input wire logic manchester_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Write strobe then a quiet cycle; decoded outputs land one later
    sequence cfg_wr_s;
        wr_en ##1 !wr_en;
    endsequence
    wr_pulse_a: assert property (wr_en |=> !wr_en)
        else $error("write strobe longer than one cycle");
    rd_update_a: assert property (wr_en |=> rd_data == $past(wr_data))
        else $error("register did not take written value");
    rd_hold_a: assert property (!wr_en |=> $stable(rd_data))
        else $error("register changed without a write");
    // Host must filter forbidden values before they reach the device
    mod_legal_a: assert property (
        wr_en |-> wr_data[6:4] inside {3'h0, 3'h1, 3'h3, 3'h4})
        else $error("reserved modulation code forwarded");
    manch_fsk_a: assert property (
        (wr_en && wr_data[6:4] == 3'h4) |-> !wr_data[3])
        else $error("Manchester forwarded with 4-FSK");
    bypass_out_a: assert property (
        cfg_wr_s |=> dc_filter_bypass_o == $past(wr_data[7], 2))
        else $error("filter bypass output wrong");
    mod_out_a: assert property (
        cfg_wr_s |=> modulation_select_o == $past(wr_data[6:4], 2))
        else $error("modulation output wrong");
    manch_out_a: assert property (
        cfg_wr_s |=> manchester_en_o == $past(wr_data[3], 2))
        else $error("Manchester enable output wrong");
endmodule : mfs_checker

// file: tb.sv
// Self-checking bench: host and modem ends joined by mfs_if.
// Assumes Wishbone map and latencies from the designer's hand-over.
`timescale 1ns/1ps
module tb;
    logic clk_i, rst_b_i, cyc, stb, we, ack, err, e, t;
    logic rxb, rxv, car, txb, byp, manch, txc, found;
    logic [7:0] adr;
    logic [7:0] fwd;
    logic [3:0] sel;
    logic [2:0] mods;
    logic [15:0] sw;
    logic [31:0] wdat, rdat, q, pat;
    integer fail_count, n_checks, seed, cfg_m, rate_m, asy_m;
    integer i, j, k, m, er, ex;
    mfs_if u_mfs_if();
    mfs_dev u_mfs_dev(.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg(u_mfs_if),
        .rx_bit_i(rxb), .rx_valid_i(rxv), .carrier_i(car), .tx_bit_i(txb),
        .sync_word_i(sw), .dc_filter_bypass_o(byp),
        .modulation_select_o(mods), .manchester_en_o(manch),
        .tx_chip_o(txc), .sync_found_o(found));
    mfs_host u_mfs_host(.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg(u_mfs_if),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .cfg_wr_en_o(), .cfg_wr_data_o(fwd));
    mfs_checker u_mfs_checker(.clk_i(clk_i), .rst_b_i(rst_b_i),
        .wr_en(u_mfs_if.wr_en), .wr_data(u_mfs_if.wr_data),
        .rd_data(u_mfs_if.rd_data), .dc_filter_bypass_o(byp),
        .modulation_select_o(mods), .manchester_en_o(manch));
    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task chk(input string nm, input logic [31:0] exv, input logic [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exv) begin
            fail_count = fail_count + 1;
            $display("Error %s expected %h seen %h", nm, exv, got);
        end
    endtask : chk
    // Classic cycle; waits for ack or err under a bound, never a fixed count
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        k = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && err !== 1'b1 && k < 20) begin
            @(posedge clk_i);
            k = k + 1;
        end
        q = rdat;
        e = err;
        {cyc, stb} <= 2'b00;
        if (k == 20) begin
            fail_count = fail_count + 1;
            final_report();
        end
    endtask : wb
    // Valid held two cycles, low two, so the pin synchroniser sees an edge
    task send_bit(input logic b);
        @(posedge clk_i);
        rxb <= b;
        rxv <= 1'b1;
        repeat (2) @(posedge clk_i);
        rxv <= 1'b0;
        @(posedge clk_i);
    endtask : send_bit
    // Model of what the host lets through to the device
    function automatic logic legal(input logic [7:0] v);
        return v[6:4] inside {3'h0, 3'h1, 3'h3, 3'h4}
            && !(v[3] && (v[6:4] == 3'h4 || asy_m != 0))
            && !(v[7] && rate_m > 250);
    endfunction : legal
    task final_report;
        $display("Checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count = fail_count + 1;
        final_report();
    end
    initial begin
        seed = 32'hB6BB;
        {fail_count, n_checks, cyc, stb, we, adr, wdat} = '0;
        {rst_b_i, rxb, rxv, car, txb, sw} = '0;
        sel = 4'hF;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        wb(1'b0, 8'h04, 32'h0);
        chk("reset value", 32'h02, q);
        cfg_m = 2;
        // Random rates around the bypass limit; first 8 walk every code
        for (i = 0; i < 60; i = i + 1) begin
            rate_m = 240 + ($random(seed) & 15);
            asy_m = $random(seed) & 1;
            wb(1'b1, 8'h00, {23'h0, asy_m[0], rate_m[7:0]});
            j = $random(seed) & 8'hFF;
            if (i < 8) j[6:4] = i[2:0];
            ex = {(legal(j[7:0]) && j[7] != cfg_m[7]), !legal(j[7:0])};
            wb(1'b1, 8'h04, j);
            wb(1'b0, 8'h08, 32'h0);
            chk("status", ex, q & 32'h3);
            if (legal(j[7:0])) cfg_m = j;
            wb(1'b1, 8'h08, 32'h3);
            wb(1'b0, 8'h04, 32'h0);
            chk("config", cfg_m, q);
            chk("forwarded", cfg_m, fwd);
            chk("outputs", cfg_m[7:3], {byp, mods, manch});
        end
        wb(1'b0, 8'h0C, 32'h0);
        chk("unmapped err", 32'h1, e);
        $display("Test register access done");
        // Line coding: chip toggles with constant data only when enabled
        wb(1'b1, 8'h00, 32'h64);
        txb <= 1'b1;
        wb(1'b1, 8'h04, 32'h0A);
        repeat (3) @(posedge clk_i);
        t = txc;
        @(posedge clk_i);
        chk("chip toggle", 32'h1, t ^ txc);
        wb(1'b1, 8'h04, 32'h02);
        repeat (3) @(posedge clk_i);
        chk("chip plain", txb, txc);
        $display("Test line coding done");
        // Every qualifier against 0 to 3 bit errors at the window end
        for (m = 0; m < 8; m = m + 1) begin
            for (er = 0; er < 4; er = er + 1) begin
                wb(1'b1, 8'h04, m);
                pat = $random(seed);
                sw <= pat[15:0];
                car <= pat[20];
                pat = {pat[15:0], pat[15:0]} ^ ((32'h1 << er) - 32'h1);
                for (i = 31; i >= 0; i = i - 1) send_bit(~pat[i]);
                for (i = 31; i >= 0; i = i - 1) send_bit(pat[i]);
                repeat (6) @(posedge clk_i);
                ex = (m % 4 == 1) ? er < 2 : (m % 4 == 2) ? er == 0
                    : (m % 4 == 3) ? er < 3 : m == 4;
                if (m > 3) ex = ex && car;
                chk("sync found", ex, found);
            end
        end
        $display("Test sync qualifier done");
        // Manchester receive: chip pairs must decode to the sync word
        wb(1'b1, 8'h04, 32'h0A);
        pat = $random(seed);
        sw <= pat[15:0];
        for (i = 15; i >= 0; i = i - 1) begin
            send_bit(pat[i]);
            send_bit(~pat[i]);
        end
        repeat (6) @(posedge clk_i);
        chk("manchester sync", 32'h1, found);
        $display("Test Manchester receive done");
        final_report();
    end
endmodule : tb
